/* shared/fbsgc_pkg.sv */
// Purpose: constants and types of the fieldbus slave global control block
// Assumes: word-indexed Avalon-MM register map, 32-bit data
// Notes: buffer indices 2 bits; 00 names buffer 4 (substitute slot)
//
// Operation
// - control message only in cyclic exchange, only from locking master
// - control message with over two payload bytes or no buffer: reject
// - header bytes 0-5, control byte 6, group mask byte 7
// - act if membership AND mask nonzero, or mask zero
// - reserved bit 7, 6 or 0 set: unsupported flag, drop master
// - sync moves output bus buffer to pending, raises output ready
// - sync or freeze without capability acts like a reserved bit
// - unsync leaves sync mode and moves output data to pending
// - freeze takes pending input into bus buffer and holds it
// - unfreeze ends freezing and takes new pending input
// - clear sets cleared mode, raises irq; fetch swaps substitute
// - with pin routing set, sync drives output ready onto PB3
// - store control byte of valid messages; cell resets to FFh
// - command irq: mode 0 on change, mode 1 on every message
// - zero-length output exchange accepted; substitute joins rotation
// - read inputs: zero length, cyclic exchange, any master, record
// - read inputs: no service while waiting, no resource if length
// - repeated read inputs returns newly published input data
// - read outputs: same acceptance and rejection as read inputs
// - repeated read outputs returns newly fetched output data
// - get configuration always, no resource if request data
package fbsgc_pkg;
  localparam logic [2:0] REG_CONFIG = 3'h0;
  localparam logic [2:0] REG_DOUT_LEN = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_COMMAND = 3'h3;
  localparam logic [2:0] REG_SCB = 3'h4;
  localparam int HDR_BYTES = 6;
  localparam int CTRL_BYTE_POS = 6;
  localparam int GROUP_BYTE_POS = 7;
  localparam int CTRL_SYNC = 5;
  localparam int CTRL_UNSYNC = 4;
  localparam int CTRL_FREEZE = 3;
  localparam int CTRL_UNFREEZE = 2;
  localparam int CTRL_CLEAR = 1;
  localparam logic [7:0] CTRL_RESERVED = 8'hC1;
  localparam logic [7:0] GC_MAX_LEN = 8'h02;
  localparam logic [7:0] LAST_CMD_RESET = 8'hFF;
  localparam int CMD_FETCH = 0;
  localparam int CMD_NEW_DIN = 1;
  localparam int CMD_CLR_NS = 2;
  localparam logic [1:0] BUF_D_RESET = 2'h1;
  localparam logic [1:0] BUF_N_RESET = 2'h2;
  localparam logic [1:0] BUF_U_RESET = 2'h3;
  localparam logic [1:0] BUF_C_RESET = 2'h0;
  typedef enum logic [2:0] {
    SVC_WR_RD = 3'b000, SVC_GC = 3'b001, SVC_RD_IN = 3'b010,
    SVC_RD_OUT = 3'b011, SVC_GET_CFG = 3'b100
  } fbsgc_svc_type;
  typedef enum logic [1:0] {
    ST_WAIT_PRM = 2'b00, ST_WAIT_CFG = 2'b01, ST_DATA_EXCH = 2'b10
  } fbsgc_slave_type;
  typedef enum logic [1:0] {
    RESP_OK = 2'b00, RESP_IGNORED = 2'b01,
    RESP_NO_SERVICE = 2'b10, RESP_NO_RESOURCE = 2'b11
  } fbsgc_resp_type;
  typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} fbsgc_bus_type;
  typedef struct packed {
    logic route_irq_to_pin;
    logic control_irq_mode;
    logic freeze_cap;
    logic sync_cap;
    logic skip_reserved_check;
    logic [6:0] master_addr;
    logic [7:0] group;
  } fbsgc_cfg_type;
  typedef struct packed {
    fbsgc_svc_type kind;
    logic [6:0] src;
    logic [7:0] len;
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic buf_avail;
  } fbsgc_svc_req_type;
endpackage : fbsgc_pkg

/* rtl/fbsgc_top.sv */
// Purpose: global control, read services and buffer rotation of a slave
// Assumes: protocol engine delivers one service per SVC_VALID pulse
// Notes: all state in one struct; outputs straight from flip-flops
`timescale 1ns/1ps
module fbsgc_top import fbsgc_pkg::*; #(
  parameter int DATA_W = 32
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic CLK_EN,
  input wire logic [2:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA,
  output logic [DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic SVC_VALID,
  input wire fbsgc_svc_req_type SVC_REQ,
  input wire fbsgc_slave_type SLAVE_STATE,
  output logic RESP_VALID,
  output fbsgc_resp_type RESP_CODE,
  output logic [1:0] RESP_BUF,
  output logic OUTPUT_READY_IRQ,
  output logic CONTROL_COMMAND_IRQ,
  output logic PORT_PB3,
  output logic DROP_MASTER
);
  if (DATA_W != 32) begin : g_chk
    $error("fbsgc_top serves 32-bit data only");
  end

  typedef struct packed {
    fbsgc_bus_type bus;
    logic waitreq;
    logic [31:0] readdata;
    fbsgc_cfg_type cfg;
    logic [7:0] dout_len;
    logic [7:0] last_cmd;
    logic not_sup;
    logic sync_mode;
    logic freeze_mode;
    logic pend_clr;
    logic u_clr;
    logic [1:0] od;
    logic [1:0] on;
    logic [1:0] ou;
    logic [1:0] oc;
    logic d_full;
    logic on_new;
    logic [1:0] id;
    logic [1:0] in;
    logic [1:0] iu;
    logic in_new;
    logic scb_in_ok;
    logic [6:0] scb_in_src;
    logic scb_out_ok;
    logic [6:0] scb_out_src;
    logic resp_valid;
    fbsgc_resp_type resp_code;
    logic [1:0] resp_buf;
    logic out_irq;
    logic cmd_irq;
    logic pb3;
    logic drop;
  } fbsgc_state_type;

  fbsgc_state_type s;
  fbsgc_state_type next_s;
  logic fetch;
  logic new_din;
  logic gc_ok;
  logic grp_hit;
  logic bad;
  logic gc_act;
  logic [7:0] ctrl;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd_word(input fbsgc_state_type t,
                                         input logic [2:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      REG_CONFIG: w = {12'h000, t.cfg};
      REG_DOUT_LEN: w = {24'h00_0000, t.dout_len};
      REG_STATUS: w = {20'h0_0000, t.pend_clr, t.freeze_mode,
                       t.sync_mode, t.not_sup, t.last_cmd};
      REG_COMMAND: w = {15'h0000, t.in_new, t.on_new, t.u_clr,
                        t.id, t.in, t.iu, t.oc, t.od, t.on, t.ou};
      REG_SCB: w = {16'h0000, t.scb_out_ok, t.scb_out_src,
                    t.scb_in_ok, t.scb_in_src};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : rd_word

  // ----------------------------------------------------------------
  // control message decode
  // ----------------------------------------------------------------
  assign ctrl = SVC_REQ.ctrl;
  assign gc_ok = SVC_REQ.kind == SVC_GC
    && SLAVE_STATE == ST_DATA_EXCH
    && SVC_REQ.src == s.cfg.master_addr
    && SVC_REQ.len <= GC_MAX_LEN && SVC_REQ.buf_avail;
  assign grp_hit = (s.cfg.group & SVC_REQ.mask) != 8'h00
    || SVC_REQ.mask == 8'h00;
  assign bad = (!s.cfg.skip_reserved_check
                && (ctrl & CTRL_RESERVED) != 8'h00)
    || (ctrl[CTRL_SYNC] && !s.cfg.sync_cap)
    || (ctrl[CTRL_FREEZE] && !s.cfg.freeze_cap);
  assign gc_act = SVC_VALID && gc_ok && grp_hit && !bad;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    fetch = 1'b0;
    new_din = 1'b0;
    next_s.resp_valid = 1'b0;
    next_s.out_irq = 1'b0;
    next_s.cmd_irq = 1'b0;
    next_s.pb3 = 1'b0;
    next_s.drop = 1'b0;
    // one wait state: answer comes the edge after the request is seen
    case (s.bus)
      BUS_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          next_s.bus = BUS_ACK;
          next_s.waitreq = 1'b0;
          next_s.readdata = AVS_READ ? rd_word(s, AVS_ADDRESS) : 32'h0;
        end
      end
      BUS_ACK: begin
        next_s.bus = BUS_IDLE;
        next_s.waitreq = 1'b1;
        if (AVS_WRITE) begin
          case (AVS_ADDRESS)
            REG_CONFIG: next_s.cfg = AVS_WRITEDATA[19:0];
            REG_DOUT_LEN: next_s.dout_len = AVS_WRITEDATA[7:0];
            REG_COMMAND: begin
              fetch = AVS_WRITEDATA[CMD_FETCH];
              new_din = AVS_WRITEDATA[CMD_NEW_DIN];
              // clear first, so a same-cycle set below wins
              if (AVS_WRITEDATA[CMD_CLR_NS]) begin
                next_s.not_sup = 1'b0;
              end
            end
            default: ;
          endcase
        end
      end
      default: begin
        next_s.bus = BUS_IDLE;
        next_s.waitreq = 1'b1;
      end
    endcase
    if (SVC_VALID) begin
      next_s.resp_valid = 1'b1;
      next_s.resp_code = RESP_OK;
      next_s.resp_buf = s.id;
      case (SVC_REQ.kind)
        SVC_GC: begin
          if (!gc_ok) begin
            next_s.resp_code = RESP_IGNORED;
          end else if (!grp_hit) begin
            next_s.resp_code = RESP_IGNORED;
          end else if (bad) begin
            next_s.not_sup = 1'b1;
            next_s.drop = 1'b1;
          end else begin
            next_s.last_cmd = ctrl;
            next_s.cmd_irq = s.cfg.control_irq_mode
              || ctrl != s.last_cmd;
            if (ctrl[CTRL_SYNC] || ctrl[CTRL_UNSYNC]) begin
              next_s.sync_mode = ctrl[CTRL_SYNC];
              if (s.d_full) begin
                {next_s.od, next_s.on} = {s.on, s.od};
                next_s.on_new = 1'b1;
                next_s.d_full = 1'b0;
              end
              next_s.out_irq = 1'b1;
              next_s.pb3 = ctrl[CTRL_SYNC]
                && s.cfg.route_irq_to_pin;
            end
            if (ctrl[CTRL_FREEZE] || ctrl[CTRL_UNFREEZE]) begin
              next_s.freeze_mode = ctrl[CTRL_FREEZE];
              if (s.in_new) begin
                {next_s.id, next_s.in} = {s.in, s.id};
                next_s.in_new = 1'b0;
              end
            end
            if (ctrl[CTRL_CLEAR]) begin
              next_s.pend_clr = 1'b1;
              next_s.on_new = 1'b1;
              next_s.out_irq = 1'b1;
            end
          end
        end
        SVC_WR_RD: begin
          if (SLAVE_STATE != ST_DATA_EXCH
              || SVC_REQ.src != s.cfg.master_addr) begin
            next_s.resp_code = RESP_IGNORED;
          end else if (SVC_REQ.len == 8'h00 && s.dout_len != 8'h00) begin
            next_s.pend_clr = 1'b1;
            next_s.on_new = 1'b1;
            next_s.out_irq = 1'b1;
          end else if (SVC_REQ.len != s.dout_len) begin
            next_s.resp_code = RESP_NO_RESOURCE;
          end else if (s.sync_mode) begin
            next_s.d_full = 1'b1;
          end else begin
            {next_s.od, next_s.on} = {s.on, s.od};
            next_s.on_new = 1'b1;
            next_s.out_irq = 1'b1;
          end
          if (!s.freeze_mode && s.in_new) begin
            {next_s.id, next_s.in} = {s.in, s.id};
            next_s.in_new = 1'b0;
            next_s.resp_buf = s.in;
          end
        end
        SVC_RD_IN, SVC_RD_OUT: begin
          if (SLAVE_STATE != ST_DATA_EXCH) begin
            next_s.resp_code = RESP_NO_SERVICE;
          end else if (SVC_REQ.len != 8'h00) begin
            next_s.resp_code = RESP_NO_RESOURCE;
          end else if (SVC_REQ.kind == SVC_RD_IN) begin
            next_s.scb_in_ok = 1'b1;
            next_s.scb_in_src = SVC_REQ.src;
            if (!s.freeze_mode && s.in_new) begin
              {next_s.id, next_s.in} = {s.in, s.id};
              next_s.in_new = 1'b0;
              next_s.resp_buf = s.in;
            end
          end else begin
            next_s.scb_out_ok = 1'b1;
            next_s.scb_out_src = SVC_REQ.src;
            next_s.resp_buf = s.ou;
          end
        end
        SVC_GET_CFG: begin
          if (SVC_REQ.len != 8'h00) begin
            next_s.resp_code = RESP_NO_RESOURCE;
          end
        end
        default: next_s.resp_code = RESP_IGNORED;
      endcase
    end
    // user fetch after the exchange above, so it sees fresh data
    if (fetch) begin
      if (next_s.on_new && next_s.pend_clr) begin
        {next_s.ou, next_s.oc} = {next_s.oc, next_s.ou};
        next_s.u_clr = 1'b1;
      end else if (next_s.on_new) begin
        {next_s.ou, next_s.on} = {next_s.on, next_s.ou};
        next_s.u_clr = 1'b0;
      end
      next_s.on_new = 1'b0;
      next_s.pend_clr = 1'b0;
    end
    if (new_din) begin
      {next_s.iu, next_s.in} = {next_s.in, next_s.iu};
      next_s.in_new = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.last_cmd <= LAST_CMD_RESET;
      s.od <= BUF_D_RESET;
      s.on <= BUF_N_RESET;
      s.ou <= BUF_U_RESET;
      s.oc <= BUF_C_RESET;
      s.id <= BUF_D_RESET;
      s.in <= BUF_N_RESET;
      s.iu <= BUF_U_RESET;
    end else if (CLK_EN) begin
      s <= next_s;
    end
  end

  assign AVS_READDATA = s.readdata;
  assign AVS_WAITREQUEST = s.waitreq;
  assign RESP_VALID = s.resp_valid;
  assign RESP_CODE = s.resp_code;
  assign RESP_BUF = s.resp_buf;
  assign OUTPUT_READY_IRQ = s.out_irq;
  assign CONTROL_COMMAND_IRQ = s.cmd_irq;
  assign PORT_PB3 = s.pb3;
  assign DROP_MASTER = s.drop;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  a_gc_state_gate: assert property (
    CLK_EN && SVC_VALID && SVC_REQ.kind == SVC_GC
    && SLAVE_STATE != ST_DATA_EXCH
    |=> RESP_CODE == RESP_IGNORED && $stable(s.last_cmd))
    else $error("control message taken outside cyclic exchange");
  a_gc_len_gate: assert property (
    CLK_EN && SVC_VALID && SVC_REQ.kind == SVC_GC
    && SVC_REQ.len > GC_MAX_LEN
    |=> RESP_CODE == RESP_IGNORED && !OUTPUT_READY_IRQ)
    else $error("long control message taken");
  a_reserved_drop: assert property (
    CLK_EN && SVC_VALID && gc_ok && grp_hit && bad
    |=> DROP_MASTER && s.not_sup && !CONTROL_COMMAND_IRQ)
    else $error("reserved bit did not drop master");
  a_sync_irq: assert property (
    CLK_EN && gc_act && ctrl[CTRL_SYNC]
    |=> OUTPUT_READY_IRQ && s.sync_mode ##1 !OUTPUT_READY_IRQ || !CLK_EN)
    else $error("sync gave no single output ready pulse");
  a_pin_route: assert property (
    CLK_EN && gc_act && ctrl[CTRL_SYNC] && s.cfg.route_irq_to_pin
    |=> PORT_PB3 && OUTPUT_READY_IRQ)
    else $error("pin route missed on sync");
  a_last_cmd: assert property (
    CLK_EN && gc_act |=> s.last_cmd == $past(SVC_REQ.ctrl))
    else $error("control byte not stored");
  a_irq_mode: assert property (
    CLK_EN && gc_act && !s.cfg.control_irq_mode
    && SVC_REQ.ctrl == s.last_cmd |=> !CONTROL_COMMAND_IRQ)
    else $error("mode 0 irq fired on unchanged byte");
  a_rdin_reject: assert property (
    CLK_EN && SVC_VALID && SVC_REQ.kind == SVC_RD_IN
    && SLAVE_STATE == ST_DATA_EXCH && SVC_REQ.len != 8'h00
    |=> RESP_VALID && RESP_CODE == RESP_NO_RESOURCE)
    else $error("read inputs with length not refused");
  a_getcfg_ok: assert property (
    CLK_EN && SVC_VALID && SVC_REQ.kind == SVC_GET_CFG
    && SVC_REQ.len == 8'h00 |=> RESP_CODE == RESP_OK)
    else $error("get configuration refused");
  a_bus_answer: assert property (
    (AVS_READ || AVS_WRITE) && CLK_EN && s.bus == BUS_IDLE
    |=> !AVS_WAITREQUEST)
    else $error("bus request not answered");
  // flags and modes only: a same-cycle user fetch may still move buffers
  a_gc_ignore_quiet: assert property (
    CLK_EN && SVC_VALID && SVC_REQ.kind == SVC_GC && !gc_ok
    |=> !OUTPUT_READY_IRQ && !CONTROL_COMMAND_IRQ && !DROP_MASTER
    && $stable(s.last_cmd) && $stable(s.sync_mode)
    && $stable(s.freeze_mode))
    else $error("ignored control message changed state");
  a_freeze_hold: assert property (
    CLK_EN && SVC_VALID && SVC_REQ.kind == SVC_WR_RD && s.freeze_mode
    |=> $stable(s.id))
    else $error("frozen input buffer moved on exchange");
  a_unfreeze_take: assert property (
    CLK_EN && gc_act && ctrl[CTRL_UNFREEZE] && !ctrl[CTRL_FREEZE]
    && s.in_new |=> !s.freeze_mode && s.id == $past(s.in))
    else $error("unfreeze did not take new input");
  a_clear_mode: assert property (
    CLK_EN && gc_act && ctrl[CTRL_CLEAR]
    |=> OUTPUT_READY_IRQ && (s.pend_clr || s.u_clr))
    else $error("clear did not set cleared mode");
  a_failsafe_take: assert property (
    CLK_EN && SVC_VALID && SVC_REQ.kind == SVC_WR_RD
    && SLAVE_STATE == ST_DATA_EXCH && SVC_REQ.src == s.cfg.master_addr
    && SVC_REQ.len == 8'h00 && s.dout_len != 8'h00
    |=> RESP_CODE == RESP_OK && OUTPUT_READY_IRQ
    && (s.pend_clr || s.u_clr))
    else $error("empty exchange not taken as failsafe");
  a_rdin_record: assert property (
    CLK_EN && SVC_VALID && SVC_REQ.kind == SVC_RD_IN
    && SLAVE_STATE == ST_DATA_EXCH && SVC_REQ.len == 8'h00
    |=> RESP_CODE == RESP_OK && s.scb_in_ok
    && s.scb_in_src == $past(SVC_REQ.src))
    else $error("read inputs not recorded");

  c_sync: cover property (gc_act && ctrl[CTRL_SYNC] && s.d_full);
  c_freeze: cover property (gc_act && ctrl[CTRL_FREEZE] && s.in_new);
  c_failsafe: cover property (fetch && s.pend_clr && s.on_new);
  c_reserved: cover property (SVC_VALID && gc_ok && grp_hit && bad);
  c_clear: cover property (gc_act && ctrl[CTRL_CLEAR]);
endmodule : fbsgc_top

/* dv/fbsgc_master_model.sv */
// Purpose: bus master station issuing services to the slave block
// Assumes: caller enters just after a rising edge of clk
// Notes: released request lines show the inverse, never stale values
`timescale 1ns/1ps
module fbsgc_master_model import fbsgc_pkg::*; (
  input wire logic clk,
  output logic svc_valid,
  output fbsgc_svc_req_type svc_req
);
  // --------
  // requests
  // --------
  initial begin
    svc_valid = 1'b0;
    svc_req = '0;
  end
  // control byte and group mask travel in their own fields
  task automatic send(input fbsgc_svc_req_type r);
    svc_valid <= 1'b1;
    svc_req <= r;
    @(posedge clk);
    svc_valid <= 1'b0;
    svc_req <= ~r;
  endtask : send
  // poll with full output length, bytes all zero
  task automatic poll(input logic [7:0] dlen, input logic [6:0] me);
    send('{kind:SVC_WR_RD, src:me, len:dlen, ctrl:8'h00, mask:8'h00,
      buf_avail:1'b1});
  endtask : poll
endmodule : fbsgc_master_model

/* dv/tb_fieldbus_slave_global_control.sv */
// Purpose: self-checking bench for the slave global control block
// Assumes: clock enable held high, slave state driven by the bench
// Notes: buffer indices compared only where the behaviour fixes them
`timescale 1ns/1ps
module tb_fieldbus_slave_global_control import fbsgc_pkg::*;;
  localparam logic [6:0] MA = 7'h12;
  localparam logic [31:0] CFG = 32'h000B1205;
  localparam logic [40:0] DR [6] = '{{CFG, 8'h80, 1'b1},
    {CFG, 8'h40, 1'b1}, {CFG, 8'h01, 1'b1}, {32'h000A1205, 8'h20, 1'b1},
    {32'h00091205, 8'h08, 1'b1}, {32'h000B9205, 8'h01, 1'b0}};
  localparam logic [14:0] RT [9] = '{
    {SVC_RD_IN, ST_WAIT_PRM, 8'h00, RESP_NO_SERVICE},
    {SVC_RD_IN, ST_WAIT_CFG, 8'h00, RESP_NO_SERVICE},
    {SVC_RD_IN, ST_DATA_EXCH, 8'h01, RESP_NO_RESOURCE},
    {SVC_RD_OUT, ST_WAIT_CFG, 8'h00, RESP_NO_SERVICE},
    {SVC_RD_OUT, ST_DATA_EXCH, 8'h02, RESP_NO_RESOURCE},
    {SVC_GET_CFG, ST_WAIT_PRM, 8'h01, RESP_NO_RESOURCE},
    {SVC_GET_CFG, ST_WAIT_PRM, 8'h00, RESP_OK},
    {SVC_RD_IN, ST_DATA_EXCH, 8'h00, RESP_OK},
    {SVC_RD_OUT, ST_DATA_EXCH, 8'h00, RESP_OK}};
  logic MCLK, ARST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [2:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q1, q2;
  logic SVC_VALID, RESP_VALID, OUTPUT_READY_IRQ;
  logic CONTROL_COMMAND_IRQ, PORT_PB3, DROP_MASTER;
  logic [1:0] RESP_BUF;
  fbsgc_svc_req_type SVC_REQ;
  fbsgc_slave_type SLAVE_STATE;
  fbsgc_resp_type RESP_CODE;
  int error_cnt = 0;
  int comparisons = 0;

  fbsgc_top #(.DATA_W(32)) dut (.MCLK(MCLK), .ARST_N(ARST_N),
    .CLK_EN(1'b1), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .SVC_VALID(SVC_VALID), .SVC_REQ(SVC_REQ), .SLAVE_STATE(SLAVE_STATE),
    .RESP_VALID(RESP_VALID), .RESP_CODE(RESP_CODE), .RESP_BUF(RESP_BUF),
    .OUTPUT_READY_IRQ(OUTPUT_READY_IRQ), .PORT_PB3(PORT_PB3),
    .CONTROL_COMMAND_IRQ(CONTROL_COMMAND_IRQ), .DROP_MASTER(DROP_MASTER));
  fbsgc_master_model m (.clk(MCLK), .svc_valid(SVC_VALID),
    .svc_req(SVC_REQ));

  always #10 MCLK = ~MCLK;

  // -----
  // tasks
  // -----
  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // waits on waitrequest without assuming its latency
  task automatic bus(input logic w, input logic [2:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= !w;
    AVS_WRITE <= w;
    do begin
      @(posedge MCLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdm(input string n, input logic [2:0] a,
    input logic [31:0] k, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, q & k, e);
  endtask : rdm
  task automatic svc(input fbsgc_svc_type k, input fbsgc_slave_type st,
    input logic [6:0] s, input logic [7:0] l, c, g, input logic a);
    @(posedge MCLK);
    SLAVE_STATE <= st;
    m.send('{kind:k, src:s, len:l, ctrl:c, mask:g, buf_avail:a});
    #1;
  endtask : svc
  task automatic gc(input logic [7:0] c, g);
    svc(SVC_GC, ST_DATA_EXCH, MA, 8'h02, c, g, 1'b1);
  endtask : gc
  // pulses in order: output ready, command, pin, drop
  task automatic rsp(input fbsgc_resp_type c, input logic [3:0] k, f);
    chk("resp_valid", RESP_VALID, 1'b1);
    chk("resp_code", RESP_CODE, c);
    chk("pulses", {OUTPUT_READY_IRQ, CONTROL_COMMAND_IRQ, PORT_PB3,
      DROP_MASTER} & k, f);
  endtask : rsp
  task automatic ign(input fbsgc_slave_type st, input logic [6:0] s,
    input logic [7:0] l, g, input logic a);
    svc(SVC_GC, st, s, l, 8'h20, g, a);
    rsp(RESP_IGNORED, 4'hF, 4'h0);
  endtask : ign
  task automatic pol;
    @(posedge MCLK);
    SLAVE_STATE <= ST_DATA_EXCH;
    m.poll(8'h04, MA);
    #1;
    chk("poll_code", RESP_CODE, RESP_OK);
  endtask : pol
  // repeated read must point at a different buffer after a user swap
  task automatic rep(input fbsgc_svc_type k, input logic [31:0] c);
    logic [1:0] b;
    svc(k, ST_DATA_EXCH, 7'h33, 8'h00, 8'h00, 8'h00, 1'b1);
    b = RESP_BUF;
    pol();
    wr(REG_COMMAND, c);
    pol();
    svc(k, ST_DATA_EXCH, 7'h33, 8'h00, 8'h00, 8'h00, 1'b1);
    chk("repeat_buf", RESP_BUF !== b, 1'b1);
  endtask : rep
  task automatic final_report;
    $display("compared %0d, mismatched %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // -----
  // tests
  // -----
  initial begin
    MCLK = 1'b0;
    ARST_N = 1'b0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 3'h0;
    AVS_WRITEDATA = 32'h0;
    SLAVE_STATE = ST_WAIT_PRM;
    repeat (4) @(posedge MCLK);
    ARST_N <= 1'b1;
    rdm("status", REG_STATUS, 32'hFFF, 32'h0FF);
    rdm("bufs", REG_COMMAND, 32'h1FFFF, 32'h01B1B);
    rdm("unmapped", 3'h5, 32'hFFFFFFFF, 32'h0);
    wr(REG_CONFIG, CFG);
    wr(REG_DOUT_LEN, 32'h4);
    $display("test reset done");
    ign(ST_WAIT_CFG, MA, 8'h02, 8'h00, 1'b1);
    ign(ST_DATA_EXCH, 7'h13, 8'h02, 8'h00, 1'b1);
    ign(ST_DATA_EXCH, MA, 8'h03, 8'h00, 1'b1);
    ign(ST_DATA_EXCH, MA, 8'h02, 8'h00, 1'b0);
    ign(ST_DATA_EXCH, MA, 8'h02, 8'h0A, 1'b1);
    rdm("cell", REG_STATUS, 32'hFFF, 32'h0FF);
    rdm("bufs", REG_COMMAND, 32'h1FFFF, 32'h01B1B);
    $display("test ignored done");
    gc(8'h20, 8'h04);
    rsp(RESP_OK, 4'hF, 4'hE);
    rdm("status", REG_STATUS, 32'h2FF, 32'h220);
    wr(REG_COMMAND, 32'h1);
    pol();
    rdm("n_new", REG_COMMAND, 32'h8000, 32'h0);
    gc(8'h20, 8'h00);
    rsp(RESP_OK, 4'hF, 4'hA);
    rdm("n_new", REG_COMMAND, 32'h8000, 32'h8000);
    wr(REG_COMMAND, 32'h1);
    pol();
    gc(8'h10, 8'h00);
    rsp(RESP_OK, 4'h7, 4'h4);
    rdm("status", REG_STATUS, 32'h2FF, 32'h010);
    rdm("n_new", REG_COMMAND, 32'h8000, 32'h8000);
    $display("test sync done");
    wr(REG_COMMAND, 32'h2);
    gc(8'h08, 8'h00);
    rsp(RESP_OK, 4'h5, 4'h4);
    rdm("status", REG_STATUS, 32'h4FF, 32'h408);
    rdm("in_new", REG_COMMAND, 32'h10000, 32'h0);
    wr(REG_COMMAND, 32'h2);
    pol();
    rdm("in_new", REG_COMMAND, 32'h10000, 32'h10000);
    gc(8'h04, 8'h00);
    rsp(RESP_OK, 4'h5, 4'h4);
    rdm("status", REG_STATUS, 32'h4FF, 32'h004);
    rdm("in_new", REG_COMMAND, 32'h10000, 32'h0);
    $display("test freeze done");
    foreach (DR[i]) begin
      wr(REG_CONFIG, DR[i][40:9]);
      gc(DR[i][8:1], 8'h00);
      rsp(RESP_OK, 4'h1, {3'h0, DR[i][0]});
      rdm("unsup", REG_STATUS, 32'h100, {23'h0, DR[i][0], 8'h0});
      wr(REG_COMMAND, 32'h4);
    end
    $display("test reserved done");
    wr(REG_CONFIG, 32'h000F1205);
    bus(1'b0, REG_COMMAND, 32'h0, q1);
    repeat (2) begin
      gc(8'h02, 8'h00);
      rsp(RESP_OK, 4'hC, 4'hC);
    end
    bus(1'b0, REG_COMMAND, 32'h0, q2);
    chk("out_bufs", q2[7:0], q1[7:0]);
    rdm("cleared", REG_STATUS, 32'h800, 32'h800);
    wr(REG_COMMAND, 32'h1);
    rdm("u_clr", REG_COMMAND, 32'h4003, 32'h4000);
    pol();
    wr(REG_COMMAND, 32'h1);
    rdm("u_clr", REG_COMMAND, 32'h4000, 32'h0);
    svc(SVC_WR_RD, ST_DATA_EXCH, MA, 8'h00, 8'h00, 8'h00, 1'b1);
    rsp(RESP_OK, 4'h8, 4'h8);
    wr(REG_COMMAND, 32'h1);
    rdm("u_clr", REG_COMMAND, 32'h4000, 32'h4000);
    $display("test clear done");
    foreach (RT[i]) begin
      svc(fbsgc_svc_type'(RT[i][14:12]), fbsgc_slave_type'(RT[i][11:10]),
        7'h33, RT[i][9:2], 8'h00, 8'h00, 1'b1);
      rsp(fbsgc_resp_type'(RT[i][1:0]), 4'h0, 4'h0);
    end
    rdm("scb", REG_SCB, 32'hFFFF, 32'hB3B3);
    rep(SVC_RD_IN, 32'h2);
    rep(SVC_RD_OUT, 32'h1);
    $display("test reads done");
    final_report();
  end

  // sequence needs well under 3000 cycles; cut off at 5000
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule : tb_fieldbus_slave_global_control
